/* File: vtq_consts.vh */
// Purpose: shared constants of the VLAN tag and priority queue block
// Assumes: included by every design file of the block
// Notes:   definitions only
`ifndef VTQ_CONSTS_VH
`define VTQ_CONSTS_VH
`define VTQ_VLAN_W        12
`define VTQ_PRI_W         3
`define VTQ_RESET_VLAN    12'h001
`define VTQ_VLAN_MAX      12'h800
`define VTQ_RESET_PRI     3'h0
`define VTQ_RESET_THRESH  3'h4
`define VTQ_FIFO_DEPTH    8
`define VTQ_VLAN_SLOTS    256
`define VTQ_MAC_W         48
`define VTQ_ST_IDLE       2'h0
`define VTQ_ST_DECIDE     2'h1
`define VTQ_ST_PUSH       2'h2
`endif

/* File: vtq_fifo.v */
// Purpose: descriptor FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   ready on the write side falls only when truly full
`include "vtq_consts.vh"
module vtq_fifo #(
   parameter W     = 32,
   parameter DEPTH = `VTQ_FIFO_DEPTH,
   parameter AW    = 3
) (
   input  wire         mclk,
   input  wire         rst_n,
   input  wire         wr_valid,
   output wire         wr_ready,
   input  wire [W-1:0] wr_data,
   output wire         rd_valid,
   input  wire         rd_ready,
   output wire [W-1:0] rd_data
);
   reg [W-1:0]  mem_q [0:DEPTH-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0]   cnt_q;
   wire         do_wr;
   wire         do_rd;

   assign wr_ready = (cnt_q != DEPTH[AW:0]);
   assign rd_valid = (cnt_q != {(AW+1){1'b0}});
   assign rd_data  = mem_q[rp_q];
   assign do_wr    = wr_valid && wr_ready;
   assign do_rd    = rd_valid && rd_ready;

   always @(posedge mclk) begin
      if (do_wr) begin
         mem_q[wp_q] <= wr_data;
      end
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wp_q <= wp_q + 1'b1;
         end
         if (do_rd) begin
            rp_q <= rp_q + 1'b1;
         end
         if (do_wr && !do_rd) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (do_rd && !do_wr) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // vtq_fifo

/* File: vtq_mac_learn.v */
// Purpose: small associative table of source address to port
// Assumes: one lookup and one learn per cycle
// Notes:   round-robin replacement; old stations may be evicted early
`include "vtq_consts.vh"
module vtq_mac_learn #(
   parameter N  = 16,
   parameter NW = 4,
   parameter PW = 5
) (
   input  wire                  mclk,
   input  wire                  rst_n,
   input  wire [`VTQ_MAC_W-1:0] lk_mac,
   output reg                   lk_hit,
   output reg  [PW-1:0]         lk_port,
   input  wire                  learn_en,
   input  wire [`VTQ_MAC_W-1:0] learn_mac,
   input  wire [PW-1:0]         learn_port
);
   reg [`VTQ_MAC_W-1:0] mac_q  [0:N-1];
   reg [PW-1:0]         port_q [0:N-1];
   reg [N-1:0]          ok_q;
   reg [NW-1:0]         rr_q;
   wire [N-1:0]         lk_m;
   wire [N-1:0]         ln_m;
   integer              i;
   integer              j;

   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_cmp
         assign lk_m[g] = ok_q[g] && (mac_q[g] == lk_mac);
         assign ln_m[g] = ok_q[g] && (mac_q[g] == learn_mac);
      end
   endgenerate

   always @* begin
      lk_hit  = 1'b0;
      lk_port = {PW{1'b0}};
      for (i = 0; i < N; i = i + 1) begin
         if (lk_m[i]) begin
            lk_hit  = 1'b1;
            lk_port = port_q[i];
         end
      end
   end

   // Known station only moves port; new one takes the next slot
   always @(posedge mclk) begin
      if (!rst_n) begin
         ok_q <= {N{1'b0}};
         rr_q <= {NW{1'b0}};
      end else if (learn_en) begin
         if (|ln_m) begin
            for (j = 0; j < N; j = j + 1) begin
               if (ln_m[j]) begin
                  port_q[j] <= learn_port;
               end
            end
         end else begin
            mac_q[rr_q]  <= learn_mac;
            port_q[rr_q] <= learn_port;
            ok_q[rr_q]   <= 1'b1;
            rr_q         <= rr_q + 1'b1;
         end
      end
   end
endmodule // vtq_mac_learn

/* File: vtq_top.v */
// Purpose: VLAN classification, membership, tag decision and two-level queuing
// Assumes: one frame descriptor per handshake; payload moves elsewhere
// Notes:   VLAN table is a direct-mapped set of slots, one VLAN per slot
`include "vtq_consts.vh"
// Behaviour
// - Frames are classified by a four-byte tag holding VLAN number and priority.
// - At most 256 VLANs held; VLAN numbers 1 through 2048 only.
// - VLAN mode is on from reset; every internal descriptor carries a VLAN.
// - After reset every port is an untagged member of VLAN 1.
// - Untagged arrivals take the receiving port's default VLAN; the code gives an untagged join the VLAN from its tag field.
// - Tagged arrivals take the VLAN number from their tag.
// - Learn source address to port; forward or flood by destination.
// - Tag is removed on egress ports with untagged membership, after port choice.
// - Untagged arrivals leaving tagged ports get the ingress default VLAN tag.
// - A port may join many VLANs, each tagged or untagged.
// - Join request adds the receiving port, then goes out all other ports; the code skips the add when another VLAN owns the slot.
// - Unknown VLAN frames pass only while automatic registration is enabled; the code passes a join to all other ports regardless.
// - Two transmit queues, high and normal, chosen by frame priority.
// - High queue is served first; normal only when high is empty.
// - Priority comes from the tag, or from the ingress port when untagged.
// - Tag priority is read as a value 0 through 7.
// - Untagged frames get a per-port default priority 0 through 7.
// - Priority at or above the global threshold, reset 4, is high.
module vtq_top #(
   parameter NP  = 24,
   parameter PW  = 5,
   parameter SW  = 8,
   parameter MCN = 16,
   parameter MCW = 4
) (
   input  wire                  mclk,
   input  wire                  rst_n,
   input  wire                  in_valid,
   output reg                   in_ready_q,
   input  wire [PW-1:0]         in_port,
   input  wire                  in_tagged,
   input  wire [11:0]           in_tag_vlan,
   input  wire [2:0]            in_tag_pri,
   input  wire [47:0]           in_src_mac,
   input  wire [47:0]           in_dst_mac,
   input  wire                  in_join,
   input  wire                  cfg_port_we,
   input  wire [PW-1:0]         cfg_port_idx,
   input  wire [11:0]           cfg_port_default_vlan,
   input  wire [2:0]            cfg_port_pri,
   input  wire                  cfg_vlan_we,
   input  wire                  cfg_vlan_del,
   input  wire [11:0]           cfg_vlan_number,
   input  wire [NP-1:0]         cfg_member_mask,
   input  wire [NP-1:0]         cfg_untag_mask,
   input  wire                  cfg_thresh_we,
   input  wire [2:0]            cfg_thresh,
   input  wire                  auto_reg_en,
   output reg                   out_valid_q,
   input  wire                  out_ready,
   output reg  [NP-1:0]         out_port_mask_q,
   output reg  [NP-1:0]         out_tag_mask_q,
   output reg                   out_add_tag_q,
   output reg  [11:0]           out_vlan_number_q,
   output reg  [2:0]            out_pri_q,
   output reg                   out_high_q,
   output reg                   drop_q,
   output reg  [2:0]            thresh_q
);
   localparam NSL = `VTQ_VLAN_SLOTS;
   localparam DW  = 2*NP + 17;
   localparam [1:0] ST_IDLE   = `VTQ_ST_IDLE;
   localparam [1:0] ST_DECIDE = `VTQ_ST_DECIDE;
   localparam [1:0] ST_PUSH   = `VTQ_ST_PUSH;

   reg [11:0]   slot_vlan [0:NSL-1];
   reg [NP-1:0] slot_mem  [0:NSL-1];
   reg [NP-1:0] slot_untg [0:NSL-1];
   reg [NSL-1:0] slot_ok_q;
   reg [11:0]   pdv_q [0:NP-1];
   reg [2:0]    pdp_q [0:NP-1];

   reg [1:0]    st_q;
   reg [PW-1:0] port_q;
   reg          tagged_q;
   reg          join_q;
   reg [11:0]   vlan_q;
   reg [2:0]    pri_q;
   reg [47:0]   src_q;
   reg [47:0]   dst_q;
   reg [NP-1:0] dmask_q;
   reg [NP-1:0] dtag_q;
   reg          ddrop_q;
   reg          dhigh_q;
   reg [NP-1:0] dmask_d;
   reg [NP-1:0] dtag_d;

   wire           lk_hit;
   wire [PW-1:0]  lk_port;
   wire [SW-1:0]  slot;
   wire           known;
   wire           in_rng;
   wire [NP-1:0]  ing_bit;
   wire [NP-1:0]  others;
   wire [NP-1:0]  all_ports;
   wire           join_hold;
   wire           push_v;
   wire           hi_wr_rdy;
   wire           lo_wr_rdy;
   wire           sel_rdy;
   wire           push_done;
   wire [DW-1:0]  push_word;
   wire           hi_v;
   wire           lo_v;
   wire [DW-1:0]  hi_w;
   wire [DW-1:0]  lo_w;
   wire           take;
   wire [DW-1:0]  sel_w;
   integer        i;

   function in_range;
      input [11:0] v;
      begin
         in_range = (v != 12'h000) && (v <= `VTQ_VLAN_MAX);
      end
   endfunction

   function [SW-1:0] slot_of;
      input [11:0] v;
      begin
         slot_of = v[SW-1:0];
      end
   endfunction

   function [NP-1:0] onehot;
      input [PW-1:0] p;
      begin
         onehot = {{(NP-1){1'b0}}, 1'b1} << p;
      end
   endfunction

   assign all_ports = {NP{1'b1}};
   assign slot      = slot_of(vlan_q);
   assign in_rng    = in_range(vlan_q);
   assign known     = in_rng && slot_ok_q[slot] && (slot_vlan[slot] == vlan_q);
   assign ing_bit   = onehot(port_q);
   assign others    = all_ports & ~ing_bit;

   // Forwarding decision from VLAN membership and learned destination
   always @* begin
      dmask_d = {NP{1'b0}};
      dtag_d  = {NP{1'b0}};
      if (join_q) begin
         dmask_d = others;
      end else if (!known) begin
         if (auto_reg_en && in_rng) begin
            dmask_d = others;
            dtag_d  = others;
         end
      end else begin
         if (lk_hit) begin
            dmask_d = onehot(lk_port) & slot_mem[slot] & others;
         end else begin
            dmask_d = slot_mem[slot] & others;
         end
         dtag_d = dmask_d & ~slot_untg[slot];
      end
   end

   vtq_mac_learn #(
      .N  (MCN),
      .NW (MCW),
      .PW (PW)
   ) u_learn (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .lk_mac     (dst_q),
      .lk_hit     (lk_hit),
      .lk_port    (lk_port),
      .learn_en   (push_done),
      .learn_mac  (src_q),
      .learn_port (port_q)
   );

   // Join must not race a configuration write to the same table
   assign join_hold = join_q && cfg_vlan_we;
   assign push_v    = (st_q == ST_PUSH) && !ddrop_q && !join_hold;
   assign sel_rdy   = dhigh_q ? hi_wr_rdy : lo_wr_rdy;
   assign push_done = (st_q == ST_PUSH) && !join_hold && (ddrop_q || sel_rdy);
   assign push_word = {dhigh_q, pri_q, vlan_q, !tagged_q, dtag_q, dmask_q};

   always @(posedge mclk) begin
      if (!rst_n) begin
         st_q       <= ST_IDLE;
         in_ready_q <= 1'b0;
         port_q     <= {PW{1'b0}};
         tagged_q   <= 1'b0;
         join_q     <= 1'b0;
         vlan_q     <= `VTQ_RESET_VLAN;
         pri_q      <= `VTQ_RESET_PRI;
         src_q      <= 48'h000000000000;
         dst_q      <= 48'h000000000000;
         dmask_q    <= {NP{1'b0}};
         dtag_q     <= {NP{1'b0}};
         ddrop_q    <= 1'b0;
         dhigh_q    <= 1'b0;
         drop_q     <= 1'b0;
      end else begin
         drop_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               in_ready_q <= 1'b1;
               if (in_valid && in_ready_q) begin
                  in_ready_q <= 1'b0;
                  st_q       <= ST_DECIDE;
                  port_q     <= in_port;
                  tagged_q   <= in_tagged;
                  join_q     <= in_join;
                  src_q      <= in_src_mac;
                  dst_q      <= in_dst_mac;
                  // Untagged frames are given a tag here; a join names its VLAN in the tag field
                  vlan_q <= (in_tagged || in_join) ? in_tag_vlan : pdv_q[in_port];
                  pri_q  <= in_tagged ? in_tag_pri : pdp_q[in_port];
               end
            end
            ST_DECIDE: begin
               st_q    <= ST_PUSH;
               dmask_q <= dmask_d;
               dtag_q  <= dtag_d;
               ddrop_q <= (dmask_d == {NP{1'b0}});
               dhigh_q <= (pri_q >= thresh_q);
            end
            ST_PUSH: begin
               if (push_done) begin
                  st_q       <= ST_IDLE;
                  in_ready_q <= 1'b1;
                  drop_q     <= ddrop_q;
               end
            end
            default: begin
               st_q       <= ST_IDLE;
               in_ready_q <= 1'b0;
            end
         endcase
      end
   end

   // Per-port defaults and global threshold
   always @(posedge mclk) begin
      if (!rst_n) begin
         thresh_q <= `VTQ_RESET_THRESH;
         for (i = 0; i < NP; i = i + 1) begin
            pdv_q[i] <= `VTQ_RESET_VLAN;
            pdp_q[i] <= `VTQ_RESET_PRI;
         end
      end else begin
         if (cfg_thresh_we) begin
            thresh_q <= cfg_thresh;
         end
         if (cfg_port_we && (cfg_port_idx < NP)) begin
            pdv_q[cfg_port_idx] <= cfg_port_default_vlan;
            pdp_q[cfg_port_idx] <= cfg_port_pri;
         end
      end
   end

   // VLAN table; a slot already owned by another VLAN refuses a join, but a configuration write replaces its owner
   always @(posedge mclk) begin
      if (!rst_n) begin
         slot_vlan[slot_of(`VTQ_RESET_VLAN)] <= `VTQ_RESET_VLAN;
         slot_mem[slot_of(`VTQ_RESET_VLAN)]  <= all_ports;
         slot_untg[slot_of(`VTQ_RESET_VLAN)] <= all_ports;
      end else if (cfg_vlan_we && !cfg_vlan_del && in_range(cfg_vlan_number)) begin
         slot_vlan[slot_of(cfg_vlan_number)] <= cfg_vlan_number;
         slot_mem[slot_of(cfg_vlan_number)]  <= cfg_member_mask;
         slot_untg[slot_of(cfg_vlan_number)] <= cfg_untag_mask;
      end else if (push_done && join_q && in_rng) begin
         if (known) begin
            slot_mem[slot] <= slot_mem[slot] | ing_bit;
         end else if (!slot_ok_q[slot]) begin
            slot_vlan[slot] <= vlan_q;
            slot_mem[slot]  <= ing_bit;
            slot_untg[slot] <= {NP{1'b0}};
         end
      end
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         slot_ok_q <= {{(NSL-1){1'b0}}, 1'b1} << slot_of(`VTQ_RESET_VLAN);
      end else if (cfg_vlan_we && in_range(cfg_vlan_number)) begin
         if (!cfg_vlan_del) begin
            slot_ok_q[slot_of(cfg_vlan_number)] <= 1'b1;
         end else if (slot_vlan[slot_of(cfg_vlan_number)] == cfg_vlan_number) begin
            slot_ok_q[slot_of(cfg_vlan_number)] <= 1'b0;
         end
      end else if (push_done && join_q && in_rng && !slot_ok_q[slot]) begin
         slot_ok_q[slot] <= 1'b1;
      end
   end

   vtq_fifo #(
      .W     (DW),
      .DEPTH (`VTQ_FIFO_DEPTH),
      .AW    (3)
   ) u_hi_q (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .wr_valid (push_v && dhigh_q),
      .wr_ready (hi_wr_rdy),
      .wr_data  (push_word),
      .rd_valid (hi_v),
      .rd_ready (take && hi_v),
      .rd_data  (hi_w)
   );

   vtq_fifo #(
      .W     (DW),
      .DEPTH (`VTQ_FIFO_DEPTH),
      .AW    (3)
   ) u_lo_q (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .wr_valid (push_v && !dhigh_q),
      .wr_ready (lo_wr_rdy),
      .wr_data  (push_word),
      .rd_valid (lo_v),
      .rd_ready (take && !hi_v && lo_v),
      .rd_data  (lo_w)
   );

   // Strict priority; normal traffic can starve under steady high load
   assign take  = !out_valid_q || out_ready;
   assign sel_w = hi_v ? hi_w : lo_w;

   always @(posedge mclk) begin
      if (!rst_n) begin
         out_valid_q       <= 1'b0;
         out_port_mask_q   <= {NP{1'b0}};
         out_tag_mask_q    <= {NP{1'b0}};
         out_add_tag_q     <= 1'b0;
         out_vlan_number_q <= `VTQ_RESET_VLAN;
         out_pri_q         <= `VTQ_RESET_PRI;
         out_high_q        <= 1'b0;
      end else if (take) begin
         out_valid_q <= hi_v || lo_v;
         if (hi_v || lo_v) begin
            out_port_mask_q   <= sel_w[NP-1:0];
            out_tag_mask_q    <= sel_w[2*NP-1:NP];
            out_add_tag_q     <= sel_w[2*NP];
            out_vlan_number_q <= sel_w[2*NP+12:2*NP+1];
            out_pri_q         <= sel_w[2*NP+15:2*NP+13];
            out_high_q        <= sel_w[2*NP+16];
         end
      end
   end
endmodule // vtq_top

/* File: vtq_props.sv */
// Purpose: port-level properties of the VLAN tag and priority queue block
// Assumes: bound to vtq_top; one clock, synchronous active-low reset
// Notes:   threshold is only rewritten while no descriptor waits
module vtq_props #(
   parameter NP = 24
) (
   input logic          mclk,
   input logic          rst_n,
   input logic          in_valid,
   input logic          in_ready_q,
   input logic          cfg_thresh_we,
   input logic [2:0]    cfg_thresh,
   input logic          out_valid_q,
   input logic          out_ready,
   input logic [NP-1:0] out_port_mask_q,
   input logic [NP-1:0] out_tag_mask_q,
   input logic [11:0]   out_vlan_number_q,
   input logic [2:0]    out_pri_q,
   input logic          out_high_q,
   input logic          drop_q,
   input logic [2:0]    thresh_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_take;
      in_valid && in_ready_q;
   endsequence
   sequence s_done;
      drop_q || in_ready_q;
   endsequence
   property p_busy;
      s_take |=> !in_ready_q [*2];
   endproperty
   property p_answer;
      s_take |-> ##[2:200] s_done;
   endproperty
   property p_drop;
      drop_q |-> $past(in_valid, 3) && $past(in_ready_q, 3) ##1 !drop_q;
   endproperty
   property p_hold;
      out_valid_q && !out_ready |=> out_valid_q && $stable(out_port_mask_q) && $stable(out_vlan_number_q)
         && $stable(out_pri_q) && $stable(out_tag_mask_q);
   endproperty
   property p_high;
      out_valid_q |-> out_high_q == (out_pri_q >= thresh_q);
   endproperty
   property p_thresh;
      cfg_thresh_we |=> thresh_q == $past(cfg_thresh);
   endproperty
   property p_mask;
      out_valid_q |-> (out_tag_mask_q & ~out_port_mask_q) == '0 && out_port_mask_q != '0;
   endproperty
   property p_range;
      out_valid_q |-> out_vlan_number_q inside {[12'h001:12'h800]};
   endproperty
   property p_reset;
      $rose(rst_n) |-> thresh_q == 3'h4 && !out_valid_q && !in_ready_q;
   endproperty
   a_busy: assert property (p_busy) else $error("ingress ready too early");
   a_answer: assert property (p_answer) else $error("descriptor never completed");
   a_drop: assert property (p_drop) else $error("drop without a take");
   a_hold: assert property (p_hold) else $error("output changed while stalled");
   a_high: assert property (p_high) else $error("queue flag against threshold");
   a_thresh: assert property (p_thresh) else $error("threshold not written");
   a_mask: assert property (p_mask) else $error("bad egress masks");
   a_range: assert property (p_range) else $error("VLAN number out of range");
   a_reset: assert property (p_reset) else $error("bad reset state");
endmodule // vtq_props

/* File: vtq_sink.sv */
// Purpose: egress link consumer of queued descriptors
// Assumes: bench raises hold to stall the link
// Notes:   slow mode refuses at random, like a congested port
module vtq_sink (
   input  logic mclk,
   input  logic hold,
   input  logic slow,
   output logic out_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   initial out_ready = 1'b0;
   always @(negedge mclk) begin
      out_ready <= !hold && !(slow && $urandom_range(2) == 0);
   end
endmodule // vtq_sink

/* File: vtq_tb.sv */
// Purpose: self-checking bench of vtq_top against a queue model
// Assumes: inputs change on the falling edge
// Notes:   eight station addresses only, so the learn table never evicts
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst_n, in_valid, in_tagged, in_join, cfg_port_we, cfg_vlan_we, cfg_vlan_del;
   logic        cfg_thresh_we, auto_reg_en, hold, slow, in_ready_q, out_ready, out_valid_q;
   logic        out_add_tag_q, out_high_q, drop_q, sf, ed;
   logic [4:0]  in_port, cfg_port_idx;
   logic [11:0] in_tag_vlan, cfg_port_default_vlan, cfg_vlan_number, out_vlan_number_q;
   logic [2:0]  in_tag_pri, cfg_port_pri, cfg_thresh, out_pri_q, thresh_q;
   logic [47:0] in_src_mac, in_dst_mac;
   logic [23:0] cfg_member_mask, cfg_untag_mask, out_port_mask_q, out_tag_mask_q;
   logic [23:0] mem[int], unt[int];
   logic [65:0] stg, e, hq[$], nq[$];
   int          pv[24], pp[24], mp[logic [47:0]], th, failures, cmp_count;
   int          vpick[3] = '{1, 5, 9};
   vtq_top vtq_top_i (.*);
   vtq_sink vtq_sink_i (.mclk(mclk), .hold(hold), .slow(slow), .out_ready(out_ready));
   initial begin
      mclk = 0;
      forever #2 mclk = ~mclk;
   end
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [65:0] s, input logic [65:0] x);
      cmp_count++;
      if (s !== x) begin
         failures++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
      end
   endtask
   always @(posedge mclk) if (rst_n && out_valid_q === 1'b1 && out_ready) begin
      check({1'b1, out_vlan_number_q, out_tag_mask_q, out_port_mask_q}, {sf, stg[59:0]});
      if (!stg[65]) check({out_add_tag_q, out_high_q, out_pri_q}, stg[64:60]);
      if (hq.size()) stg = hq.pop_front();
      else if (nq.size()) stg = nq.pop_front();
      else sf = 0;
   end
   function automatic logic [47:0] mac(int k);
      return {40'h0A_0000_0000, k[7:0]};
   endfunction
   task automatic decide(int p, bit tg, int v, int pr, int sk, int dk, bit jn);
      logic [23:0] oth, m, t;
      int vl, pi;
      oth = ~(24'h1 << p);
      vl = (tg || jn) ? v : pv[p];
      pi = tg ? pr : pp[p];
      if (jn) begin
         m = oth;
         t = '0;
         if (!mem.exists(vl)) unt[vl] = '0;
         mem[vl] = mem.exists(vl) ? mem[vl] | ~oth : ~oth;
      end else if (!mem.exists(vl)) begin
         m = auto_reg_en ? oth : '0;
         t = m;
      end else begin
         m = mem[vl] & oth;
         if (mp.exists(mac(dk))) m = m & (24'h1 << mp[mac(dk)]);
         t = m & ~unt[vl];
      end
      mp[mac(sk)] = p;
      ed = (m == '0);
      e = {jn, !tg, pi >= th, pi[2:0], vl[11:0], t, m};
   endtask
   task automatic settle(int lim);
      int n;
      n = 0;
      while (in_ready_q !== 1'b1 && n < lim) begin
         @(negedge mclk);
         n++;
      end
      if (n >= lim || ed) return;
      if (!sf) {sf, stg} = {1'b1, e};
      else if (e[63]) hq.push_back(e);
      else nq.push_back(e);
   endtask
   task automatic send(int p, bit tg, int v, int pr, int sk, int dk, bit jn, int lim);
      int n;
      @(negedge mclk);
      {in_valid, in_port, in_tagged, in_tag_vlan, in_tag_pri, in_join} = {1'b1, p[4:0], tg, v[11:0], pr[2:0], jn};
      {in_src_mac, in_dst_mac} = {mac(sk), mac(dk)};
      n = 0;
      while (in_ready_q !== 1'b1 && n < 300) begin
         @(negedge mclk);
         n++;
      end
      @(negedge mclk);
      in_valid = 0;
      decide(p, tg, v, pr, sk, dk, jn);
      @(negedge mclk);
      @(negedge mclk);
      check(drop_q, ed);
      settle(lim);
   endtask
   task automatic cfg_vlan(int v, logic [23:0] m, logic [23:0] u, bit del);
      @(negedge mclk);
      {cfg_vlan_we, cfg_vlan_number, cfg_member_mask, cfg_untag_mask, cfg_vlan_del} = {1'b1, v[11:0], m, u, del};
      @(negedge mclk);
      cfg_vlan_we = 0;
      if (v < 1 || v > 2048) return;
      if (del) mem.delete(v);
      else {mem[v], unt[v]} = {m, u};
   endtask
   task automatic wait_idle;
      for (int n = 0; n < 500 && sf; n++) @(negedge mclk);
   endtask
   initial begin
      #80000;
      failures++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      complete_run;
   end
   initial begin
      void'($urandom(22));
      {rst_n, in_valid, in_tagged, in_join, cfg_port_we, cfg_vlan_we, cfg_vlan_del, cfg_thresh_we} = '0;
      {auto_reg_en, hold, slow, sf, in_port, cfg_port_idx, in_tag_vlan, cfg_port_default_vlan} = '0;
      {cfg_vlan_number, in_tag_pri, cfg_port_pri, cfg_thresh, in_src_mac, in_dst_mac} = '0;
      {cfg_member_mask, cfg_untag_mask, th} = {48'h0, 32'd4};
      foreach (pv[i]) {pv[i], pp[i]} = {32'd1, 32'd0};
      {mem[1], unt[1]} = {24'hFFFFFF, 24'hFFFFFF};
      repeat (5) @(negedge mclk);
      check({in_ready_q, out_valid_q, drop_q}, 3'b000);
      rst_n = 1;
      @(negedge mclk);
      check(thresh_q, 3'h4);
      send(0, 0, 0, 0, 1, 7, 0, 50);
      send(2, 1, 1, 4, 2, 1, 0, 50);
      send(4, 1, 1, 3, 3, 7, 0, 50);
      $display("test defaults done");
      cfg_vlan(5, 24'h00008A, 24'h000080, 0);
      @(negedge mclk);
      {cfg_port_we, cfg_port_idx, cfg_port_default_vlan, cfg_port_pri} = {1'b1, 5'd3, 12'h005, 3'h6};
      @(negedge mclk);
      {cfg_port_we, pv[3], pp[3]} = {1'b0, 32'd5, 32'd6};
      send(3, 0, 0, 0, 3, 6, 0, 50);
      send(1, 1, 5, 2, 4, 3, 0, 50);
      send(7, 1, 5, 2, 5, 4, 0, 50);
      cfg_vlan(2049, 24'h000003, 24'h0, 0);
      cfg_vlan(2048, 24'h000003, 24'h0, 0);
      send(0, 1, 2048, 1, 6, 7, 0, 50);
      send(0, 1, 2049, 1, 6, 7, 0, 50);
      cfg_vlan(2048, 24'h0, 24'h0, 1);
      send(2, 1, 2048, 1, 6, 7, 0, 50);
      auto_reg_en = 1;
      send(2, 1, 9, 5, 6, 7, 0, 50);
      send(2, 1, 20, 0, 0, 7, 1, 50);
      send(5, 0, 20, 0, 3, 7, 1, 50);
      send(4, 1, 20, 1, 5, 7, 0, 50);
      $display("test membership done");
      wait_idle;
      hold = 1;
      for (int i = 0; i < 9; i++) send(5, 1, 1, 1, 6, 7, 0, 50);
      send(5, 1, 1, 1, 6, 7, 0, 30);
      check(in_ready_q, 1'b0);
      hold = 0;
      settle(200);
      wait_idle;
      hold = 1;
      for (int i = 0; i < 4; i++) send(5, 1, 1, i < 2 ? 2 : 7, 6, 7, 0, 50);
      hold = 0;
      wait_idle;
      $display("test queues done");
      @(negedge mclk);
      {cfg_thresh_we, cfg_thresh} = {1'b1, 3'h6};
      @(negedge mclk);
      {cfg_thresh_we, th} = {1'b0, 32'd6};
      check(thresh_q, 3'h6);
      slow = 1;
      for (int i = 0; i < 120; i++) begin
         auto_reg_en = 1'($urandom_range(1));
         send($urandom_range(23), $urandom_range(1), vpick[$urandom_range(2)], $urandom_range(7),
              $urandom_range(6), $urandom_range(7), 0, 200);
      end
      slow = 0;
      wait_idle;
      check(sf, 1'b0);
      $display("test random done");
      complete_run;
   end
endmodule // testbench
bind vtq_top vtq_props #(.NP(NP)) vtq_props_i (.*);
